// ---- pwmt_channel_timer.v ----
// Purpose: four 8-bit pwm channel timers, pairable into two 16-bit channels, apb slave
// Assumes: channel clocks arrive as one-cycle tick pulses from an external prescaler
// Notes: pready is always high, so every transfer has zero wait states
`include "pwmt_defines.vh"

// Function
// - period and duty double buffered, loaded at safe points
// - disabled channel writes go straight to active
// - own 8-bit up/down counter per channel tick
// - duty match toggles output flip-flop
// - counter reads never disturb counting
// - counter write clears, counts up, loads buffers
// - disabled counter holds and later resumes
// - disabled, zero period clears counter on tick
// - counter cleared at effective period end
// - alignment bit selects left or center mode
// - left mode counts up, period match restarts
// - left frequency equals tick rate over period
// - center mode up at zero, down after period
// - center down duty match toggles, zero reloads
// - center effective period is twice period
// - two join bits make 16-bit channel pairs
// - lower-numbered channel holds high-order bytes
// - joined channel uses low-order control and pin
// - joined high-order enable ignored, pin off
// - any counter byte write clears both bytes
// - polarity sets starting level of each cycle
// - reset gives up count, disabled, idle counters
module pwmt_channel_timer (
  input wire mclk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire presc_tick_a,
  input wire scaled_tick_a,
  input wire presc_tick_b,
  input wire scaled_tick_b,
  output wire [3:0] channel_output_pin
);

  reg [3:0] channel_enable_bit_ff;
  reg [3:0] output_polarity_bit_ff;
  reg [3:0] channel_clock_select_bit_ff;
  reg [3:0] center_align_bit_ff;
  reg [1:0] join_ff;
  reg [7:0] cnt_ff [0:3];
  reg [7:0] pbuf_ff [0:3];
  reg [7:0] dbuf_ff [0:3];
  reg [7:0] pact_ff [0:3];
  reg [7:0] dact_ff [0:3];
  reg [3:0] dir_ff;
  reg [3:0] flop_ff;
  reg [3:0] pin_ff;
  reg [31:0] prdata_ff;
  reg pslverr_ff;

  reg [7:0] nxt_cnt [0:3];
  reg [7:0] nxt_pbuf [0:3];
  reg [7:0] nxt_dbuf [0:3];
  reg [7:0] nxt_pact [0:3];
  reg [7:0] nxt_dact [0:3];
  reg [3:0] nxt_dir;
  reg [3:0] nxt_flop;
  reg [3:0] nxt_pin;
  reg [31:0] nxt_prdata;
  reg nxt_err;

  reg [15:0] c;
  reg [15:0] p;
  reg [15:0] d;
  reg [15:0] nc;
  reg ndir;
  reg nfl;
  reg ld;
  reg jn;
  reg en;
  reg tk;
  reg cwr;
  integer i;
  integer h;
  integer j;
  integer k;

  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pwrite;
  wire [7:0] addr = paddr[7:0];
  wire hi_zero = (paddr[31:8] == 24'h000000);

  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign channel_output_pin = pin_ff;

  // enable that governs channel ch; joined high-order channels follow their partner
  function ctl_en;
    input integer ch;
    begin
      if (join_ff[ch >> 1]) begin
        ctl_en = channel_enable_bit_ff[ch | 1];
      end else begin
        ctl_en = channel_enable_bit_ff[ch];
      end
    end
  endfunction

  // true when addr hits register base + stride * ch
  function hit;
    input [7:0] base;
    input integer ch;
    begin
      hit = hi_zero && (addr == base + (`PWMT_OFF_STRIDE * ch[7:0]));
    end
  endfunction

  // true when addr hits the single control register at off
  function at_off;
    input [7:0] off;
    begin
      at_off = hi_zero && (addr == off);
    end
  endfunction

  // channel tick: channels 0,1 use clock a pair, channels 2,3 clock b pair
  function ch_tick;
    input integer ch;
    begin
      if (ch < 2) begin
        ch_tick = channel_clock_select_bit_ff[ch] ? scaled_tick_a : presc_tick_a;
      end else begin
        ch_tick = channel_clock_select_bit_ff[ch] ? scaled_tick_b : presc_tick_b;
      end
    end
  endfunction

  // read decode in setup phase; counters are only sampled, never changed here
  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_err = 1'b1;
    if (hi_zero) begin
      case (addr)
        `PWMT_OFF_ENABLE: begin
          nxt_prdata = {28'h0000000, channel_enable_bit_ff};
          nxt_err = 1'b0;
        end
        `PWMT_OFF_POLARITY: begin
          nxt_prdata = {28'h0000000, output_polarity_bit_ff};
          nxt_err = 1'b0;
        end
        `PWMT_OFF_CLKSEL: begin
          nxt_prdata = {28'h0000000, channel_clock_select_bit_ff};
          nxt_err = 1'b0;
        end
        `PWMT_OFF_ALIGN: begin
          nxt_prdata = {28'h0000000, center_align_bit_ff};
          nxt_err = 1'b0;
        end
        `PWMT_OFF_CTRL: begin
          nxt_prdata = {30'h0, join_ff};
          nxt_err = 1'b0;
        end
        default: begin
          nxt_err = 1'b1;
        end
      endcase
    end
    for (j = 0; j < 4; j = j + 1) begin
      if (hit(`PWMT_OFF_CNT_BASE, j)) begin
        nxt_prdata = {24'h000000, cnt_ff[j]};
        nxt_err = 1'b0;
      end
      if (hit(`PWMT_OFF_PER_BASE, j)) begin
        nxt_prdata = {24'h000000, pbuf_ff[j]};
        nxt_err = 1'b0;
      end
      if (hit(`PWMT_OFF_DTY_BASE, j)) begin
        nxt_prdata = {24'h000000, dbuf_ff[j]};
        nxt_err = 1'b0;
      end
    end
  end

  // channel engines; a joined pair runs as one 16-bit engine on the low-order channel
  always @* begin
    c = 16'h0000;
    p = 16'h0000;
    d = 16'h0000;
    nc = 16'h0000;
    ndir = `PWMT_DIR_UP;
    nfl = 1'b0;
    ld = 1'b0;
    jn = 1'b0;
    en = 1'b0;
    tk = 1'b0;
    cwr = 1'b0;
    h = 0;
    nxt_dir = dir_ff;
    nxt_flop = flop_ff;
    nxt_pin = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      nxt_cnt[i] = cnt_ff[i];
      nxt_pbuf[i] = pbuf_ff[i];
      nxt_dbuf[i] = dbuf_ff[i];
      if (wr_go && hit(`PWMT_OFF_PER_BASE, i)) begin
        nxt_pbuf[i] = pwdata[7:0];
      end
      if (wr_go && hit(`PWMT_OFF_DTY_BASE, i)) begin
        nxt_dbuf[i] = pwdata[7:0];
      end
      // disabled channel: latches track the buffer, including a write this cycle
      if (!ctl_en(i)) begin
        nxt_pact[i] = nxt_pbuf[i];
        nxt_dact[i] = nxt_dbuf[i];
      end else begin
        nxt_pact[i] = pact_ff[i];
        nxt_dact[i] = dact_ff[i];
      end
    end
    for (i = 0; i < 4; i = i + 1) begin
      h = i & 2;
      jn = join_ff[i >> 1];
      if (!(jn && (i % 2 == 0))) begin
        en = channel_enable_bit_ff[i];
        tk = ch_tick(i);
        cwr = wr_go && hit(`PWMT_OFF_CNT_BASE, i);
        if (jn) begin
          c = {cnt_ff[h], cnt_ff[i]};
          p = {pact_ff[h], pact_ff[i]};
          d = {dact_ff[h], dact_ff[i]};
          cwr = cwr | (wr_go && hit(`PWMT_OFF_CNT_BASE, h));
        end else begin
          c = {8'h00, cnt_ff[i]};
          p = {8'h00, pact_ff[i]};
          d = {8'h00, dact_ff[i]};
        end
        nc = c;
        ndir = dir_ff[i];
        nfl = flop_ff[i];
        ld = 1'b0;
        if (cwr) begin
          nc = 16'h0000;
          ndir = `PWMT_DIR_UP;
          ld = 1'b1;
          nfl = 1'b0;
        end else if (en && tk) begin
          if (center_align_bit_ff[i]) begin
            // counting up from 0 to period, then down to 0: twice the period
            if (dir_ff[i] == `PWMT_DIR_UP || c == 16'h0000) begin
              nc = c + 16'h0001;
              if (nc == p) begin
                ndir = `PWMT_DIR_DOWN;
              end else begin
                ndir = `PWMT_DIR_UP;
              end
            end else begin
              nc = c - 16'h0001;
              if (nc == 16'h0000) begin
                ndir = `PWMT_DIR_UP;
                ld = 1'b1;
              end
            end
            if (nc == d) begin
              nfl = ~nfl;
            end
            if (ld) begin
              nfl = 1'b0;
            end
          end else begin
            nc = c + 16'h0001;
            ndir = `PWMT_DIR_UP;
            if (nc == p) begin
              nc = 16'h0000;
              ld = 1'b1;
              nfl = 1'b0;
            end else if (nc == d) begin
              nfl = ~nfl;
            end
          end
        end else if (!en && tk && p == 16'h0000) begin
          nc = 16'h0000;
        end
        if (!jn) begin
          nc[15:8] = 8'h00; // plain channels wrap at 8 bits
        end
        nxt_cnt[i] = nc[7:0];
        nxt_dir[i] = ndir;
        nxt_flop[i] = nfl;
        if (ld) begin
          nxt_pact[i] = pbuf_ff[i];
          nxt_dact[i] = dbuf_ff[i];
        end
        if (jn) begin
          nxt_cnt[h] = nc[15:8];
          if (ld) begin
            nxt_pact[h] = pbuf_ff[h];
            nxt_dact[h] = dbuf_ff[h];
          end
        end
        // flop cleared at cycle start, so the polarity gives the starting level
        nxt_pin[i] = en & (nfl ^ output_polarity_bit_ff[i]);
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      channel_enable_bit_ff <= `PWMT_RST_NIBBLE;
      output_polarity_bit_ff <= `PWMT_RST_NIBBLE;
      channel_clock_select_bit_ff <= `PWMT_RST_NIBBLE;
      center_align_bit_ff <= `PWMT_RST_NIBBLE;
      join_ff <= 2'h0;
      dir_ff <= 4'h0;
      flop_ff <= 4'h0;
      pin_ff <= 4'h0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        cnt_ff[k] <= `PWMT_RST_BYTE;
        pbuf_ff[k] <= `PWMT_RST_BYTE;
        dbuf_ff[k] <= `PWMT_RST_BYTE;
        pact_ff[k] <= `PWMT_RST_BYTE;
        dact_ff[k] <= `PWMT_RST_BYTE;
      end
    end else begin
      if (wr_go && at_off(`PWMT_OFF_ENABLE)) begin
        channel_enable_bit_ff <= pwdata[3:0];
      end
      if (wr_go && at_off(`PWMT_OFF_POLARITY)) begin
        output_polarity_bit_ff <= pwdata[3:0];
      end
      if (wr_go && at_off(`PWMT_OFF_CLKSEL)) begin
        channel_clock_select_bit_ff <= pwdata[3:0];
      end
      if (wr_go && at_off(`PWMT_OFF_ALIGN)) begin
        center_align_bit_ff <= pwdata[3:0];
      end
      // changing a join bit while running gives an irregular cycle; not blocked
      if (wr_go && at_off(`PWMT_OFF_CTRL)) begin
        join_ff <= pwdata[1:0];
      end
      dir_ff <= nxt_dir;
      flop_ff <= nxt_flop;
      pin_ff <= nxt_pin;
      // captured in setup so the answer stands through the whole access cycle
      if (setup) begin
        if (pwrite) begin
          prdata_ff <= 32'h00000000;
        end else begin
          prdata_ff <= nxt_prdata;
        end
        pslverr_ff <= nxt_err;
      end
      for (k = 0; k < 4; k = k + 1) begin
        cnt_ff[k] <= nxt_cnt[k];
        pbuf_ff[k] <= nxt_pbuf[k];
        dbuf_ff[k] <= nxt_dbuf[k];
        pact_ff[k] <= nxt_pact[k];
        dact_ff[k] <= nxt_dact[k];
      end
    end
  end

endmodule

// ---- pwmt_defines.vh ----
// Purpose: register offsets, field positions and reset values of the pwm channel timer
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef PWMT_DEFINES_VH
`define PWMT_DEFINES_VH

`define PWMT_ADDR_W 8
`define PWMT_OFF_ENABLE 8'h00
`define PWMT_OFF_POLARITY 8'h04
`define PWMT_OFF_CLKSEL 8'h08
`define PWMT_OFF_ALIGN 8'h0c
`define PWMT_OFF_CTRL 8'h10
`define PWMT_OFF_CNT_BASE 8'h14
`define PWMT_OFF_PER_BASE 8'h24
`define PWMT_OFF_DTY_BASE 8'h34
`define PWMT_OFF_STRIDE 8'h04

`define PWMT_CTRL_JOIN_LOWER 0
`define PWMT_CTRL_JOIN_UPPER 1

`define PWMT_RST_BYTE 8'h00
`define PWMT_RST_NIBBLE 4'h0
`define PWMT_DIR_UP 1'b0
`define PWMT_DIR_DOWN 1'b1

`endif

// ---- pwmt_channel_timer_properties.sv ----
// Purpose: port checks for the pwm channel timer
// Assumes: shadows follow apb writes, registers reset to zero
// Notes: pin stability is only judged once ticks and bus are quiet
module pwmt_channel_timer_properties (
  input wire mclk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire presc_tick_a,
  input wire scaled_tick_a,
  input wire presc_tick_b,
  input wire scaled_tick_b,
  input wire [3:0] channel_output_pin
);
  logic [3:0] sh_ff [0:4];
  logic [7:0] bf_ff [0:7];
  logic [1:0] quiet_ff;
  wire acc = psel && penable;
  wire rd = acc && !pwrite && paddr[1:0] == 2'b00;
  wire hit_buf = paddr >= 32'h24 && paddr <= 32'h40;
  wire [2:0] bi = paddr[4:2] - 3'h1;
  wire tick = presc_tick_a | scaled_tick_a | presc_tick_b | scaled_tick_b;
  // a pin may lag its cause by two edges, so three quiet cycles are needed
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_ff <= '{default: 4'h0};
      bf_ff <= '{default: 8'h0};
      quiet_ff <= 2'h0;
    end else begin
      quiet_ff <= (tick || psel) ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
      if (acc && pwrite && paddr <= 32'h10 && paddr[1:0] == 2'b00) sh_ff[paddr[4:2]] <= pwdata[3:0];
      if (acc && pwrite && hit_buf && paddr[1:0] == 2'b00) bf_ff[bi] <= pwdata[7:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence pins_idle3;
    (channel_output_pin == 4'h0) [*3];
  endsequence
  ready_always_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && paddr > 32'h40 |-> pslverr) else $error("no error on unmapped");
  mapped_ok_a: assert property (rd && paddr <= 32'h40 |-> !pslverr) else $error("error on mapped");
  err_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0) else $error("error read not zero");
  ctl_readback_a: assert property (rd && paddr <= 32'h0c |-> prdata == {28'h0, sh_ff[paddr[3:2]]})
    else $error("control bits read wrong");
  join_readback_a: assert property (rd && paddr == 32'h10 |-> prdata == {30'h0, sh_ff[4][1:0]})
    else $error("join bits read wrong");
  buf_readback_a: assert property (rd && hit_buf |-> prdata == {24'h0, bf_ff[bi]})
    else $error("buffer read wrong");
  pins_quiet_a: assert property (quiet_ff == 2'h3 |-> $stable(channel_output_pin))
    else $error("pin moved without tick");
  reset_idle_a: assert property ($rose(arst_n) |-> pins_idle3)
    else $error("pin active after reset");
  joined_off_a: assert property ((channel_output_pin &
    {1'b0, sh_ff[4][1] & $past(sh_ff[4][1]), 1'b0, sh_ff[4][0] & $past(sh_ff[4][0])}) == 4'h0)
    else $error("joined high pin active");
endmodule

bind pwmt_channel_timer pwmt_channel_timer_properties u_props (.mclk, .arst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .presc_tick_a, .scaled_tick_a, .presc_tick_b,
  .scaled_tick_b, .channel_output_pin);

// ---- tb.sv ----
// Purpose: random and corner tests of the pwm channel timer
// Assumes: ticks four mclk apart, pins sampled just before each tick
// Notes: a per-tick model gives high times and counts
`include "pwmt_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic pta = 1'b0, sta = 1'b0, ptb = 1'b0, stb = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rdat;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [3:0] pin;
  int failures = 0, cmp_count = 0, cyc = 0, hi [4], p [4], d [4], q [4], e [4], hold [4], n1, n2, h, c, pp;
  bit [3:0] pl, ca;
  bit ss;
  always #50 mclk = ~mclk;
  pwmt_channel_timer u_pwmt_channel_timer (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .presc_tick_a(pta), .scaled_tick_a(sta), .presc_tick_b(ptb),
    .scaled_tick_b(stb), .channel_output_pin(pin));
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize;
    end
  end
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // the unselected source pulses at random and must be ignored
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      pta <= ss ? 1'($urandom) : 1'b1;
      sta <= ss ? 1'b1 : 1'($urandom);
      ptb <= ss ? 1'($urandom) : 1'b1;
      stb <= ss ? 1'b1 : 1'($urandom);
      @(posedge mclk);
      {pta, sta, ptb, stb} <= 4'h0;
      repeat (2) @(posedge mclk);
      foreach (hi[i]) hi[i] += pin[i];
    end
  endtask
  // high ticks after n ticks from a cleared counter; q and e load at the first reload from tick k on
  function automatic int model(input int p, d, q, e, k, po, al, n, output int c);
    int up = 1, f = 0, s = 0;
    c = 0;
    for (int i = 0; i < n; i++) begin
      c = (al == 0 || up) ? c + 1 : c - 1;
      if ((al == 0 && c == p) || (al != 0 && c == 0)) begin
        c = 0;
        f = 0;
        up = 1;
        if (i >= k) begin
          p = q;
          d = e;
        end
      end else begin
        if (c == p) up = 0;
        if (c == d) f = !f;
      end
      s += f ^ po;
    end
    return s;
  endfunction
  initial begin
    void'($urandom(32'h3c05b813));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int a = 0; a <= 32'h40; a += 4) wr(a, (a == 0) ? 32'h0 : $urandom);
    for (int a = 0; a <= 32'h40; a += 4) begin
      rd(a);
      `CHK("mapped error", 1'b0, err)
    end
    wr(32'h44, 32'hff);
    `CHK("unmapped write error", 1'b1, err)
    rd(32'h100);
    `CHK("unmapped read data", 32'h0, rdat)
    $display("test registers done");
    repeat (3) begin
      ss = $urandom;
      pl = $urandom;
      ca = $urandom;
      wr(`PWMT_OFF_ENABLE, 32'h0);
      wr(`PWMT_OFF_CTRL, 32'h0);
      wr(`PWMT_OFF_POLARITY, pl);
      wr(`PWMT_OFF_ALIGN, ca);
      wr(`PWMT_OFF_CLKSEL, {4{ss}});
      for (int i = 0; i < 4; i++) begin
        p[i] = 2 + $urandom % 8;
        d[i] = 1 + $urandom % (p[i] - 1);
        wr(`PWMT_OFF_PER_BASE + 4 * i, p[i]);
        wr(`PWMT_OFF_DTY_BASE + 4 * i, d[i]);
      end
      wr(`PWMT_OFF_ENABLE, 32'hf);
      tk(1);
      for (int i = 0; i < 4; i++) wr(`PWMT_OFF_CNT_BASE + 4 * i, $urandom);
      hi = '{default: 0};
      n1 = 1 + $urandom % 20;
      tk(n1);
      for (int i = 0; i < 4; i++) begin
        h = model(p[i], d[i], p[i], d[i], 0, pl[i], ca[i], n1, c);
        rd(`PWMT_OFF_CNT_BASE + 4 * i);
        `CHK("running count", c, rdat)
        q[i] = 2 + $urandom % 8;
        e[i] = 1 + $urandom % (q[i] - 1);
        wr(`PWMT_OFF_PER_BASE + 4 * i, q[i]);
        wr(`PWMT_OFF_DTY_BASE + 4 * i, e[i]);
      end
      n2 = 20 + $urandom % 30;
      tk(n2);
      for (int i = 0; i < 4; i++) begin
        h = model(p[i], d[i], q[i], e[i], n1, pl[i], ca[i], n1 + n2, c);
        `CHK("high time", h, hi[i])
        rd(`PWMT_OFF_CNT_BASE + 4 * i);
        `CHK("final count", c, rdat)
      end
      $display("test eight bit done");
    end
    wr(`PWMT_OFF_ENABLE, 32'h0);
    tk(1);
    foreach (hold[i]) begin
      rd(`PWMT_OFF_CNT_BASE + 4 * i);
      hold[i] = rdat;
    end
    tk(3);
    foreach (hold[i]) begin
      rd(`PWMT_OFF_CNT_BASE + 4 * i);
      `CHK("held count", hold[i], rdat)
    end
    `CHK("disabled pins", 4'h0, pin)
    wr(`PWMT_OFF_PER_BASE, 32'h0);
    tk(1);
    rd(`PWMT_OFF_CNT_BASE);
    `CHK("zero period count", 32'h0, rdat)
    $display("test disable done");
    ss = $urandom;
    pl = $urandom;
    ca = $urandom;
    ca[0] = !ca[1];
    ca[2] = !ca[3];
    pp = 257 + $urandom % 40;
    wr(`PWMT_OFF_CTRL, 32'h3);
    wr(`PWMT_OFF_POLARITY, pl);
    wr(`PWMT_OFF_ALIGN, ca);
    wr(`PWMT_OFF_CLKSEL, {4{ss}});
    for (int j = 0; j < 2; j++) begin
      d[j] = 1 + $urandom % (pp - 1);
      wr(`PWMT_OFF_PER_BASE + 8 * j, pp >> 8);
      wr(`PWMT_OFF_PER_BASE + 8 * j + 4, pp & 255);
      wr(`PWMT_OFF_DTY_BASE + 8 * j, d[j] >> 8);
      wr(`PWMT_OFF_DTY_BASE + 8 * j + 4, d[j] & 255);
    end
    wr(`PWMT_OFF_ENABLE, 32'hf);
    tk(1);
    wr(`PWMT_OFF_CNT_BASE + 4, 32'h0);
    wr(`PWMT_OFF_CNT_BASE + 12, 32'h0);
    hi = '{default: 0};
    tk(pp - 1);
    for (int j = 0; j < 2; j++) begin
      h = model(pp, d[j], pp, d[j], 0, pl[2 * j + 1], ca[2 * j + 1], pp - 1, c);
      `CHK("joined high time", h, hi[2 * j + 1])
      `CHK("joined high pin", 0, hi[2 * j])
      rd(`PWMT_OFF_CNT_BASE + 8 * j);
      `CHK("count high byte", c >> 8, rdat)
      rd(`PWMT_OFF_CNT_BASE + 8 * j + 4);
      `CHK("count low byte", c & 255, rdat)
      wr(`PWMT_OFF_CNT_BASE + 8 * j, 32'h0);
      rd(`PWMT_OFF_CNT_BASE + 8 * j + 4);
      `CHK("byte write clears", 32'h0, rdat)
    end
    $display("test joined done");
    summarize;
  end
endmodule
